// File: rtl/kbd_serial_link.sv
// Keyboard end of the handshaked serial link: queue plus bit transmitter.
// Assumes host_ack_in is asynchronous and toggles per the bit handshake.
module kbd_serial_link #(
    parameter int unsigned ACK_TIMEOUT_CYC = kbd_link_pkg::ACK_TIMEOUT_CYC,
    parameter int unsigned QUEUE_DEPTH = kbd_link_pkg::QUEUE_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic key_event_in,
    input wire logic key_pressed_in,
    input wire logic [6:0] key_number_in,
    input wire logic host_ack_in,
    output logic key_ready_n_out,
    output logic key_serial_data_out,
    output logic busy_out
);
    // ----------------------------------------------------------------
    // Event queue
    // ----------------------------------------------------------------
    kbd_event_if ev_if();
    logic [7:0] push_code;

    assign push_code = {key_pressed_in, key_number_in};

    kbd_event_queue #(
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .push_in(key_event_in),
        .push_code_in(push_code),
        .ev(ev_if)
    );

    // ----------------------------------------------------------------
    // Acknowledge synchroniser and edge detect
    // ----------------------------------------------------------------
    logic ack_m_q, ack_s_q, ack_p_q;
    logic ack_fall, ack_rise;

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ack_m_q <= 1'b1;
            ack_s_q <= 1'b1;
            ack_p_q <= 1'b1;
        end else begin
            ack_m_q <= host_ack_in;
            ack_s_q <= ack_m_q;
            ack_p_q <= ack_s_q;
        end
    end

    assign ack_fall = ack_p_q && !ack_s_q;
    assign ack_rise = !ack_p_q && ack_s_q;

    // ----------------------------------------------------------------
    // Bit transmitter
    // ----------------------------------------------------------------
    localparam int unsigned TW = $clog2(ACK_TIMEOUT_CYC + 1);

    kbd_link_pkg::link_state_t state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] word_q, word_d;
    logic [3:0] bit_q, bit_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic rdy_n_q, rdy_n_d;
    logic data_q, data_d;
    logic take;

    assign take = (state_q == kbd_link_pkg::ST_IDLE) && ev_if.valid;
    assign ev_if.ready = take;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        word_d = word_q;
        bit_d = bit_q;
        tmr_d = tmr_q;
        rdy_n_d = rdy_n_q;
        data_d = data_q;
        case (state_q)
            kbd_link_pkg::ST_IDLE: begin
                rdy_n_d = 1'b1;
                data_d = 1'b1;
                if (take) begin
                    word_d = ev_if.code;
                    shift_d = ev_if.code;
                    bit_d = 4'h0;
                    data_d = ev_if.code[0];
                    tmr_d = '0;
                    state_d = kbd_link_pkg::ST_SETUP;
                end
            end
            kbd_link_pkg::ST_SETUP: begin
                // Data has stood one cycle before ready falls
                rdy_n_d = 1'b0;
                tmr_d = '0;
                state_d = kbd_link_pkg::ST_WAIT_FALL;
            end
            kbd_link_pkg::ST_WAIT_FALL: begin
                tmr_d = tmr_q + 1'b1;
                if (ack_fall) begin
                    rdy_n_d = 1'b1;
                    if (bit_q == 4'(kbd_link_pkg::WORD_BITS - 1)) begin
                        data_d = 1'b1;
                    end
                    state_d = kbd_link_pkg::ST_WAIT_RISE;
                end else if (tmr_q == TW'(ACK_TIMEOUT_CYC - 1)) begin
                    rdy_n_d = 1'b1;
                    tmr_d = '0;
                    state_d = kbd_link_pkg::ST_RETRY;
                end
            end
            kbd_link_pkg::ST_WAIT_RISE: begin
                if (ack_rise) begin
                    if (bit_q == 4'(kbd_link_pkg::WORD_BITS - 1)) begin
                        state_d = kbd_link_pkg::ST_IDLE;
                    end else begin
                        bit_d = bit_q + 4'h1;
                        shift_d = {1'b0, shift_q[7:1]};
                        // Stop bit is low from its ready fall
                        data_d = (bit_q == 4'(kbd_link_pkg::DATA_BITS - 1))
                            ? 1'b0 : shift_q[1];
                        tmr_d = '0;
                        state_d = kbd_link_pkg::ST_GAP;
                    end
                end
            end
            kbd_link_pkg::ST_GAP: begin
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == TW'(kbd_link_pkg::BIT_GAP_CYC - 1)) begin
                    state_d = kbd_link_pkg::ST_SETUP;
                end
            end
            kbd_link_pkg::ST_RETRY: begin
                // Ready stays high a short while, then the word restarts
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == TW'(kbd_link_pkg::BIT_GAP_CYC - 1)) begin
                    shift_d = word_q;
                    bit_d = 4'h0;
                    data_d = word_q[0];
                    state_d = kbd_link_pkg::ST_SETUP;
                end
            end
            default: begin
                state_d = kbd_link_pkg::ST_IDLE;
                rdy_n_d = 1'b1;
                data_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state_q <= kbd_link_pkg::ST_IDLE;
            shift_q <= 8'h00;
            word_q <= 8'h00;
            bit_q <= 4'h0;
            tmr_q <= '0;
            rdy_n_q <= 1'b1;
            data_q <= 1'b1;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            word_q <= word_d;
            bit_q <= bit_d;
            tmr_q <= tmr_d;
            rdy_n_q <= rdy_n_d;
            data_q <= data_d;
        end
    end

    assign key_ready_n_out = rdy_n_q;
    assign key_serial_data_out = data_q;
    assign busy_out = (state_q != kbd_link_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_ready_release: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (state_q == kbd_link_pkg::ST_WAIT_FALL && ack_fall) |=> key_ready_n_out)
        else $error("ready not released on ack fall");
    chk_data_stable: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (!key_ready_n_out && $past(!key_ready_n_out)) |-> $stable(key_serial_data_out))
        else $error("data changed while ready low");
    chk_stop_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (!key_ready_n_out && bit_q == 4'h8) |-> !key_serial_data_out)
        else $error("stop bit not low");
    chk_idle_high: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (state_q == kbd_link_pkg::ST_IDLE) |-> (key_serial_data_out && key_ready_n_out))
        else $error("idle lines not high");
    chk_next_bit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (state_q == kbd_link_pkg::ST_WAIT_RISE && ack_rise && bit_q != 4'h8)
        |-> ##[1:8] !key_ready_n_out) else $error("next bit ready late");
    chk_back_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (state_q == kbd_link_pkg::ST_WAIT_RISE && ack_rise && bit_q == 4'h8)
        |=> state_q == kbd_link_pkg::ST_IDLE) else $error("not idle after stop");
    chk_start_ready: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        take |-> ##2 !key_ready_n_out) else $error("pending event not announced");
    chk_timeout_rel: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (state_q == kbd_link_pkg::ST_WAIT_FALL && !ack_fall
         && tmr_q == TW'(ACK_TIMEOUT_CYC - 1)) |=> key_ready_n_out ##4 bit_q == 4'h0)
        else $error("timeout restart wrong");
    chk_bit_count: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        bit_q <= 4'h8) else $error("bit index beyond stop bit");
endmodule : kbd_serial_link

// File: rtl/kbd_link_pkg.sv
// Constants and types for the keyboard serial link transmitter.
// Assumes a 200 MHz system clock and a host that acknowledges by toggling its line.
// Contract
// - Each word is eight data bits LSB first, then one stop bit.
// - Data MSB is 1 for press, 0 for release; low seven bits key number.
// - With link idle and an event pending, ready goes low.
// - Events wait in a queue; each starts its own transfer.
// - Ready is driven low once for every bit of a word.
// - A falling acknowledge edge returns ready high.
// - Data changes only after acknowledge rises, valid before ready falls; the code also raises data on the stop bit's acknowledge fall.
// - Next data bit's ready low comes within 1 ms of acknowledge rising.
// - Stop bit is low from ready falling to acknowledge falling.
// - After stop bit acknowledge falls, data and ready go high and data stays high.
// - Link returns idle on acknowledge rising after the stop bit.
// - No acknowledge fall within 250 ms: ready high, restart the word.
// - On queue overflow the overflow code is sent.
package kbd_link_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned WORD_BITS = 9;
    localparam logic [7:0] CODE_OVERFLOW = 8'hFE;
    localparam logic [7:0] CODE_DEAD = 8'hFF;
    localparam int unsigned ACK_TIMEOUT_MS = 250;
    localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned NEXT_BIT_MAX_MS = 1;
    localparam int unsigned NEXT_BIT_MAX_CYC = NEXT_BIT_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned BIT_GAP_CYC = 4;
    localparam int unsigned QUEUE_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WAIT_FALL = 3'b011,
        ST_WAIT_RISE = 3'b010,
        ST_GAP = 3'b110,
        ST_RETRY = 3'b111
    } link_state_t;
endpackage : kbd_link_pkg

// File: rtl/kbd_event_if.sv
// Event hand-off between the queue and the link transmitter.
// Assumes both ends share one clock.
interface kbd_event_if;
    logic valid;
    logic ready;
    logic [7:0] code;
    modport src(output valid, output code, input ready);
    modport dst(input valid, input code, output ready);
endinterface : kbd_event_if

// File: rtl/kbd_event_queue.sv
// Event queue for key events, with overflow marking.
// Assumes a single clock and synchronous active-low reset.
module kbd_event_queue #(
    parameter int unsigned DEPTH = kbd_link_pkg::QUEUE_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic push_in,
    input wire logic [7:0] push_code_in,
    kbd_event_if.src ev
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];
    logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ovf_q, ovf_d;
    logic pop, full;

    assign full = (cnt_q == (AW+1)'(DEPTH));
    assign ev.valid = ovf_q || (cnt_q != '0);
    // Overflow code goes out ahead of the remaining queue
    assign ev.code = ovf_q ? kbd_link_pkg::CODE_OVERFLOW : mem_q[rd_q];
    assign pop = ev.ready && !ovf_q && (cnt_q != '0);

    always_comb begin
        mem_d = mem_q;
        rd_d = rd_q;
        wr_d = wr_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        if (ev.ready && ovf_q) begin
            ovf_d = 1'b0;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push_in && (!full || pop)) begin
            mem_d[wr_q] = push_code_in;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end else if (push_in) begin
            ovf_d = 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push_in && (!full || pop)) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    chk_cnt_bound: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        cnt_q <= (AW+1)'(DEPTH)) else $error("queue count above depth");
    chk_ovf_flag: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (push_in && full && !pop) |=> ovf_q) else $error("overflow not flagged");
endmodule : kbd_event_queue

// File: sim/host_model.sv
// Host model: answers each ready fall with an acknowledge pulse unless muted, collects words.
// Assumes its own clock, unrelated in phase to the keyboard's system clock.
module host_model (
    input wire logic hclk_in,
    input wire logic mute_in,
    input wire logic [1:0] dly_in,
    input wire logic key_ready_n_in,
    input wire logic key_serial_data_in,
    output logic host_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got[$];
    logic dead_seen = 1'b0;
    logic [8:0] sh;
    logic p;
    // ------------------------------------------------------------
    // Handshake; while muted, ready falls go unanswered
    // ------------------------------------------------------------
    task automatic wait_fall();
        p = key_ready_n_in;
        forever begin
            @(posedge hclk_in);
            if (p && !key_ready_n_in && !mute_in) return;
            p = key_ready_n_in;
        end
    endtask : wait_fall

    initial begin
        host_ack_out = 1'b1;
        forever begin
            for (int i = 0; i < 9; i++) begin
                wait_fall();
                repeat (dly_in) @(posedge hclk_in);
                sh[i] = key_serial_data_in;
                #1 host_ack_out = 1'b0;
                do @(posedge hclk_in); while (!key_ready_n_in);
                repeat (dly_in) @(posedge hclk_in);
                #1 host_ack_out = 1'b1;
            end
            if (sh[7:0] == 8'hFF) dead_seen = 1'b1;
            got.push_back(sh);
        end
    end
endmodule : host_model

// File: sim/testbench.sv
// Testbench: keyboard link transmitter against the host model.
// Assumes the design files and the host model are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TO_CYC = 200;
    localparam int unsigned QD = 8;
    logic clk_sys_in = 1'b0;
    logic hclk = 1'b0;
    logic rstn_in = 1'b0;
    logic key_event_in = 1'b0;
    logic key_pressed_in = 1'b0;
    logic [6:0] key_number_in = 7'h00;
    logic host_ack_in;
    logic key_ready_n_out;
    logic key_serial_data_out;
    logic busy_out;
    logic mute = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [31:0] lfsr_q = 32'h0000_7055;
    logic [8:0] exp_q[$];
    logic rdy_p = 1'b1;
    logic dat_p = 1'b1;
    int mismatches = 0;
    int n_checks = 0;
    int n_falls = 0;
    int n_tmo = 0;
    int f0;

    kbd_serial_link #(.ACK_TIMEOUT_CYC(TO_CYC), .QUEUE_DEPTH(QD)) u_kbd_serial_link (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .key_event_in(key_event_in),
        .key_pressed_in(key_pressed_in),
        .key_number_in(key_number_in),
        .host_ack_in(host_ack_in),
        .key_ready_n_out(key_ready_n_out),
        .key_serial_data_out(key_serial_data_out),
        .busy_out(busy_out)
    );
    host_model u_host_model (
        .hclk_in(hclk),
        .mute_in(mute),
        .dly_in(dly),
        .key_ready_n_in(key_ready_n_out),
        .key_serial_data_in(key_serial_data_out),
        .host_ack_out(host_ack_in)
    );

    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    initial begin
        #7.3;
        forever #24 hclk = ~hclk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic check(input logic [8:0] got, input logic [8:0] expv);
        n_checks++;
        if (got !== expv) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, expv);
        end
    endtask : check

    task automatic push(input logic p, input logic [6:0] n, input logic hold);
        key_event_in = 1'b1;
        key_pressed_in = p;
        key_number_in = n;
        exp_q.push_back({1'b0, p, n});
        @(posedge clk_sys_in);
        #1;
        if (!hold) key_event_in = 1'b0;
    endtask : push

    // Masking bit 0 keeps random codes clear of the all-ones code
    task automatic rnd_push(input logic hold);
        lfsr_q = lfsr_next(lfsr_q);
        dly = lfsr_q[9:8];
        push(lfsr_q[7], lfsr_q[6:0] & 7'h7E, hold);
    endtask : rnd_push

    task automatic drain();
        int k;
        k = 0;
        while ((u_host_model.got.size() < exp_q.size() || busy_out !== 1'b0) && k < 20000) begin
            @(posedge clk_sys_in);
            k++;
        end
        check(9'(u_host_model.got.size()), 9'(exp_q.size()));
        while (exp_q.size() > 0 && u_host_model.got.size() > 0)
            check(u_host_model.got.pop_front(), exp_q.pop_front());
        check({7'h00, key_ready_n_out, busy_out}, 9'h002);
        exp_q.delete();
        u_host_model.got.delete();
        @(posedge clk_sys_in);
        #1;
    endtask : drain

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Line monitor and main sequence
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (rstn_in === 1'b1 && busy_out === 1'b0)
            check({8'h00, key_serial_data_out}, 9'h001);
        if (key_ready_n_out === 1'b0 && rdy_p === 1'b0)
            check({8'h00, key_serial_data_out}, {8'h00, dat_p});
        if (rdy_p === 1'b1 && key_ready_n_out === 1'b0) n_falls++;
        if (rdy_p === 1'b0 && key_ready_n_out === 1'b1 && host_ack_in === 1'b1) n_tmo++;
        rdy_p <= key_ready_n_out;
        dat_p <= key_serial_data_out;
    end

    initial begin
        repeat (20) @(posedge clk_sys_in);
        #1;
        check({6'h00, key_ready_n_out, key_serial_data_out, busy_out}, 9'h006);
        rstn_in = 1'b1;
        f0 = n_falls;
        push(1'b0, 7'h7F, 1'b0);
        drain();
        push(1'b1, 7'h00, 1'b0);
        drain();
        for (int i = 0; i < 4; i++) begin
            rnd_push(1'b0);
            drain();
        end
        for (int i = 0; i < 4; i++) rnd_push(i < 3);
        drain();
        check(9'(n_falls - f0), 9'(9 * 10));
        mute = 1'b1;
        for (int i = 0; i < 10; i++) rnd_push(i < 9);
        repeat (700) @(posedge clk_sys_in);
        #1;
        check(9'(n_tmo > 1), 9'h001);
        void'(exp_q.pop_back());
        exp_q.insert(1, {1'b0, kbd_link_pkg::CODE_OVERFLOW});
        mute = 1'b0;
        drain();
        check({8'h00, u_host_model.dead_seen}, 9'h000);
        summarize();
    end

    // Span is several times the expected run of about 20 words
    initial begin
        #300_000;
        mismatches++;
        summarize();
    end
endmodule : testbench
